// file: logic/tm16_pkg.sv
// Purpose: constants for the 16-bit timer with byte-wide register access
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one word per register
// Notes:   8-bit register data sits in bits 7:0, upper bits read zero
package tm16_pkg;
    // register byte offsets
    localparam logic [5:0] TM16_OFS_CONTROL_A  = 6'h00;
    localparam logic [5:0] TM16_OFS_CONTROL_B  = 6'h04;
    localparam logic [5:0] TM16_OFS_COUNT_LO   = 6'h08;
    localparam logic [5:0] TM16_OFS_COUNT_HI   = 6'h0c;
    localparam logic [5:0] TM16_OFS_CMP_A_LO   = 6'h10;
    localparam logic [5:0] TM16_OFS_CMP_A_HI   = 6'h14;
    localparam logic [5:0] TM16_OFS_CMP_B_LO   = 6'h18;
    localparam logic [5:0] TM16_OFS_CMP_B_HI   = 6'h1c;
    localparam logic [5:0] TM16_OFS_CAPTURE_LO = 6'h20;
    localparam logic [5:0] TM16_OFS_CAPTURE_HI = 6'h24;
    localparam logic [5:0] TM16_OFS_INT_FLAGS  = 6'h28;
    localparam logic [5:0] TM16_OFS_INT_MASK   = 6'h2c;
    localparam logic [5:0] TM16_OFS_POWER      = 6'h30;

    // control_a fields
    localparam int TM16_CA_WGM_LO  = 0;
    localparam int TM16_CA_OUT_B   = 4;
    localparam int TM16_CA_OUT_A   = 6;
    // control_b fields
    localparam int TM16_CB_CLKSEL  = 0;
    localparam int TM16_CB_WGM_HI  = 3;
    localparam int TM16_CB_CAP_SRC = 5;
    localparam int TM16_CB_CAP_EDG = 6;
    localparam int TM16_CB_FILTER  = 7;
    // flag and mask bit positions
    localparam int TM16_FLG_OVF    = 0;
    localparam int TM16_FLG_MATCH_A = 1;
    localparam int TM16_FLG_MATCH_B = 2;
    localparam int TM16_FLG_CAPTURE = 3;

    // reset values
    localparam logic [7:0]  TM16_CTRL_RST  = 8'h00;
    localparam logic [3:0]  TM16_FLAGS_RST = 4'h0;
    localparam logic [15:0] TM16_WORD_RST  = 16'h0000;
    localparam logic        TM16_POWER_RST = 1'b0;

    // counter landmarks
    localparam logic [15:0] TM16_BOTTOM    = 16'h0000;
    localparam logic [15:0] TM16_MAX       = 16'hffff;
    localparam logic [15:0] TM16_TOP_8BIT  = 16'h00ff;
    localparam logic [15:0] TM16_TOP_9BIT  = 16'h01ff;
    localparam logic [15:0] TM16_TOP_10BIT = 16'h03ff;

    // waveform mode codes that change behaviour
    localparam logic [3:0] TM16_WGM_FIX8     = 4'h1;
    localparam logic [3:0] TM16_WGM_FIX9     = 4'h2;
    localparam logic [3:0] TM16_WGM_FIX10    = 4'h3;
    localparam logic [3:0] TM16_WGM_CTC_A    = 4'h4;
    localparam logic [3:0] TM16_WGM_PWM8     = 4'h5;
    localparam logic [3:0] TM16_WGM_PWM9     = 4'h6;
    localparam logic [3:0] TM16_WGM_PWM10    = 4'h7;
    localparam logic [3:0] TM16_WGM_CTC_CAP  = 4'hc;
    localparam logic [3:0] TM16_WGM_PWM_CAP  = 4'he;
    localparam logic [3:0] TM16_WGM_PWM_A    = 4'hf;

    // clock select codes
    localparam logic [2:0] TM16_CS_STOP    = 3'h0;
    localparam logic [2:0] TM16_CS_DIV1    = 3'h1;
    localparam logic [2:0] TM16_CS_DIV8    = 3'h2;
    localparam logic [2:0] TM16_CS_DIV64   = 3'h3;
    localparam logic [2:0] TM16_CS_DIV256  = 3'h4;
    localparam logic [2:0] TM16_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TM16_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TM16_CS_EXT_RISE = 3'h7;
    localparam logic [9:0] TM16_PRE8_MASK    = 10'h007;
    localparam logic [9:0] TM16_PRE64_MASK   = 10'h03f;
    localparam logic [9:0] TM16_PRE256_MASK  = 10'h0ff;
    localparam logic [9:0] TM16_PRE1024_MASK = 10'h3ff;

    // output action codes
    localparam logic [1:0] TM16_OUT_TOGGLE = 2'h1;
    localparam logic [1:0] TM16_OUT_CLEAR  = 2'h2;
    localparam logic [1:0] TM16_OUT_SET    = 2'h3;
endpackage : tm16_pkg

// file: logic/tm16_capture_filter.sv
// Purpose: optional noise canceller for the capture event input
// Assumes: input already synchronous to mclk
// Notes:   when enabled the output follows only after TAPS equal samples
`timescale 1ns/1ps
module tm16_capture_filter #(
    parameter int TAPS = 4
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // event path
    input  wire logic din,
    input  wire logic enable,
    output logic      dout
);
    typedef struct packed {
        logic [TAPS-1:0] hist;
        logic            level;
    } tm16_filt_state_t;

    tm16_filt_state_t s_q;
    tm16_filt_state_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.hist = {s_q.hist[TAPS-2:0], din};
        if (!enable) begin
            s_d.level = din;
        end else if (&s_d.hist) begin
            s_d.level = 1'b1;
        end else if (~|s_d.hist) begin
            s_d.level = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.level;
endmodule // tm16_capture_filter

// file: logic/tm16_timer.sv
// Purpose: 16-bit timer/counter with shared high-byte staging register
// Assumes: all inputs synchronous to mclk; master follows Avalon-MM rules
// Notes:   up-counting modes only; waitrequest holds every access one cycle
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module tm16_timer #(
    parameter int FILTER_TAPS = 4
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // timer pins
    input  wire logic        external_clock_pin,
    input  wire logic        capture_input_pin,
    input  wire logic        analog_cmp_in,
    output logic             compare_a_output,
    output logic             compare_b_output,
    // status towards the interrupt controller
    output logic [3:0]       irq_req,
    output logic             at_bottom,
    output logic             at_max
);
    import tm16_pkg::*;
    typedef struct packed {
        logic [7:0]  control_a;
        logic [7:0]  control_b;
        logic [7:0]  temp;
        logic [3:0]  flags;
        logic [3:0]  mask;
        logic        power_off;
        logic [15:0] count;
        logic [15:0] cmp_a_buf;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b_buf;
        logic [15:0] cmp_b;
        logic [15:0] capture;
        logic [9:0]  presc;
        logic        ext_prev;
        logic        cap_prev;
        logic        ack;
        logic [7:0]  rdata;
        logic        out_a;
        logic        out_b;
    } tm16_state_t;

    tm16_state_t s_q;
    tm16_state_t s_d;

    logic        cap_filtered;
    logic        cap_src;
    logic [3:0]  wgm;
    logic [2:0]  clk_sel;
    logic [1:0]  mode_a;
    logic [1:0]  mode_b;
    logic [15:0] top;
    logic        pwm;
    logic        top_is_a;
    logic        top_is_cap;
    logic        ctc;
    logic        tick;
    logic        at_top;
    logic        match_a;
    logic        match_b;
    logic        cap_event;
    logic [3:0]  flag_set;
    logic [3:0]  flag_clr;
    logic        rd_take;
    logic        wr_take;
    logic [7:0]  wdat;

    assign wgm     = {s_q.control_b[TM16_CB_WGM_HI +: 2], s_q.control_a[TM16_CA_WGM_LO +: 2]};
    assign clk_sel = s_q.control_b[TM16_CB_CLKSEL +: 3];
    assign mode_a  = s_q.control_a[TM16_CA_OUT_A +: 2];
    assign mode_b  = s_q.control_a[TM16_CA_OUT_B +: 2];
    assign cap_src = s_q.control_b[TM16_CB_CAP_SRC] ? analog_cmp_in : capture_input_pin;
    assign wdat    = avs_writedata[7:0];
    assign rd_take = avs_read && !s_q.ack;
    assign wr_take = avs_write && s_q.ack;

    tm16_capture_filter #(
        .TAPS (FILTER_TAPS)
    ) u_filter (
        .mclk   (mclk),
        .rst    (rst),
        .din    (cap_src),
        .enable (s_q.control_b[TM16_CB_FILTER]),
        .dout   (cap_filtered)
    );

    always_comb begin
        top        = TM16_MAX;
        pwm        = 1'b0;
        top_is_a   = 1'b0;
        top_is_cap = 1'b0;
        ctc        = 1'b0;
        case (wgm)
            TM16_WGM_FIX8:    top = TM16_TOP_8BIT;
            TM16_WGM_FIX9:    top = TM16_TOP_9BIT;
            TM16_WGM_FIX10:   top = TM16_TOP_10BIT;
            TM16_WGM_PWM8: begin
                top = TM16_TOP_8BIT;
                pwm = 1'b1;
            end
            TM16_WGM_PWM9: begin
                top = TM16_TOP_9BIT;
                pwm = 1'b1;
            end
            TM16_WGM_PWM10: begin
                top = TM16_TOP_10BIT;
                pwm = 1'b1;
            end
            TM16_WGM_CTC_A: begin
                top      = s_q.cmp_a;
                top_is_a = 1'b1;
                ctc      = 1'b1;
            end
            TM16_WGM_PWM_A: begin
                top      = s_q.cmp_a;
                top_is_a = 1'b1;
                pwm      = 1'b1;
            end
            TM16_WGM_CTC_CAP: begin
                top        = s_q.capture;
                top_is_cap = 1'b1;
                ctc        = 1'b1;
            end
            TM16_WGM_PWM_CAP: begin
                top        = s_q.capture;
                top_is_cap = 1'b1;
                pwm        = 1'b1;
            end
            default: top = TM16_MAX;
        endcase
    end

    // power-off and clock select gate the tick
    always_comb begin
        case (clk_sel)
            TM16_CS_DIV1:     tick = 1'b1;
            TM16_CS_DIV8:     tick = (s_q.presc & TM16_PRE8_MASK) == TM16_PRE8_MASK;
            TM16_CS_DIV64:    tick = (s_q.presc & TM16_PRE64_MASK) == TM16_PRE64_MASK;
            TM16_CS_DIV256:   tick = (s_q.presc & TM16_PRE256_MASK) == TM16_PRE256_MASK;
            TM16_CS_DIV1024:  tick = s_q.presc == TM16_PRE1024_MASK;
            TM16_CS_EXT_FALL: tick = s_q.ext_prev && !external_clock_pin;
            TM16_CS_EXT_RISE: tick = !s_q.ext_prev && external_clock_pin;
            default:          tick = 1'b0;
        endcase
        tick = tick && !s_q.power_off;
    end

    assign at_top  = s_q.count == top;
    assign match_a = tick && (s_q.count == s_q.cmp_a);
    assign match_b = tick && (s_q.count == s_q.cmp_b);
    assign cap_event = !s_q.power_off && (s_q.control_b[TM16_CB_CAP_EDG]
                       ? (!s_q.cap_prev && cap_filtered) : (s_q.cap_prev && !cap_filtered));

    always_comb begin
        s_d          = s_q;
        s_d.ack      = (avs_read || avs_write) && !s_q.ack;
        s_d.ext_prev = external_clock_pin;
        s_d.cap_prev = cap_filtered;
        s_d.presc    = s_q.power_off ? 10'h000 : s_q.presc + 10'h001;
        flag_set     = 4'h0;
        flag_clr     = 4'h0;

        if (tick) begin
            s_d.count = at_top ? TM16_BOTTOM : s_q.count + 16'h0001;
            // overflow at max in ctc, else at top
            if (ctc ? (s_q.count == TM16_MAX) : at_top) begin
                flag_set[TM16_FLG_OVF] = 1'b1;
            end
            // pwm compare values load at top only
            if (pwm && at_top) begin
                s_d.cmp_a = s_q.cmp_a_buf;
                s_d.cmp_b = s_q.cmp_b_buf;
            end
        end

        flag_set[TM16_FLG_MATCH_A] = match_a;
        flag_set[TM16_FLG_MATCH_B] = match_b;

        // output waveforms
        if (pwm) begin
            if (match_b) begin
                s_d.out_b = mode_b == TM16_OUT_SET;
            end else if (tick && at_top) begin
                s_d.out_b = mode_b == TM16_OUT_CLEAR;
            end
            // compare A as top drives no pwm output
            if (top_is_a) begin
                s_d.out_a = 1'b0;
            end else if (match_a) begin
                s_d.out_a = mode_a == TM16_OUT_SET;
            end else if (tick && at_top) begin
                s_d.out_a = mode_a == TM16_OUT_CLEAR;
            end
        end else begin
            if (match_a) begin
                case (mode_a)
                    TM16_OUT_TOGGLE: s_d.out_a = !s_q.out_a;
                    TM16_OUT_CLEAR:  s_d.out_a = 1'b0;
                    TM16_OUT_SET:    s_d.out_a = 1'b1;
                    default:         s_d.out_a = s_q.out_a;
                endcase
            end
            if (match_b) begin
                case (mode_b)
                    TM16_OUT_TOGGLE: s_d.out_b = !s_q.out_b;
                    TM16_OUT_CLEAR:  s_d.out_b = 1'b0;
                    TM16_OUT_SET:    s_d.out_b = 1'b1;
                    default:         s_d.out_b = s_q.out_b;
                endcase
            end
        end

        // capture copies count unless capture is top
        if (cap_event && !top_is_cap) begin
            s_d.capture                = s_q.count;
            flag_set[TM16_FLG_CAPTURE] = 1'b1;
        end

        // read side effects, data registered for the answer cycle
        if (rd_take) begin
            case (avs_address)
                TM16_OFS_CONTROL_A:  s_d.rdata = s_q.control_a;
                TM16_OFS_CONTROL_B:  s_d.rdata = s_q.control_b;
                TM16_OFS_COUNT_LO: begin
                    s_d.rdata = s_q.count[7:0];
                    s_d.temp  = s_q.count[15:8];
                end
                TM16_OFS_CAPTURE_LO: begin
                    s_d.rdata = s_q.capture[7:0];
                    s_d.temp  = s_q.capture[15:8];
                end
                TM16_OFS_COUNT_HI:   s_d.rdata = s_q.temp;
                TM16_OFS_CAPTURE_HI: s_d.rdata = s_q.temp;
                TM16_OFS_CMP_A_LO:   s_d.rdata = s_q.cmp_a_buf[7:0];
                TM16_OFS_CMP_A_HI:   s_d.rdata = s_q.cmp_a_buf[15:8];
                TM16_OFS_CMP_B_LO:   s_d.rdata = s_q.cmp_b_buf[7:0];
                TM16_OFS_CMP_B_HI:   s_d.rdata = s_q.cmp_b_buf[15:8];
                TM16_OFS_INT_FLAGS:  s_d.rdata = {4'h0, s_q.flags};
                TM16_OFS_INT_MASK:   s_d.rdata = {4'h0, s_q.mask};
                TM16_OFS_POWER:      s_d.rdata = {7'h00, s_q.power_off};
                default:             s_d.rdata = 8'h00;
            endcase
        end

        if (wr_take) begin
            case (avs_address)
                TM16_OFS_CONTROL_A:  s_d.control_a = wdat;
                TM16_OFS_CONTROL_B:  s_d.control_b = wdat;
                // high writes go to staging only
                TM16_OFS_COUNT_HI,
                TM16_OFS_CMP_A_HI,
                TM16_OFS_CMP_B_HI,
                TM16_OFS_CAPTURE_HI: s_d.temp = wdat;
                TM16_OFS_COUNT_LO:   s_d.count = {s_q.temp, wdat};
                TM16_OFS_CMP_A_LO: begin
                    s_d.cmp_a_buf = {s_q.temp, wdat};
                    if (!pwm) begin
                        s_d.cmp_a = {s_q.temp, wdat};
                    end
                end
                TM16_OFS_CMP_B_LO: begin
                    s_d.cmp_b_buf = {s_q.temp, wdat};
                    if (!pwm) begin
                        s_d.cmp_b = {s_q.temp, wdat};
                    end
                end
                TM16_OFS_CAPTURE_LO: s_d.capture = {s_q.temp, wdat};
                TM16_OFS_INT_FLAGS:  flag_clr = wdat[3:0];
                TM16_OFS_INT_MASK:   s_d.mask = wdat[3:0];
                TM16_OFS_POWER:      s_d.power_off = wdat[0];
                default:             s_d.rdata = s_q.rdata;
            endcase
        end

        // set wins over a write-one clear
        s_d.flags = (s_q.flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q           <= '0;
            s_q.control_a <= TM16_CTRL_RST;
            s_q.control_b <= TM16_CTRL_RST;
            s_q.flags     <= TM16_FLAGS_RST;
            s_q.mask      <= TM16_FLAGS_RST;
            s_q.power_off <= TM16_POWER_RST;
            s_q.count     <= TM16_WORD_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest  = (avs_read || avs_write) && !s_q.ack;
    assign avs_readdata     = {24'h000000, s_q.rdata};
    assign compare_a_output = s_q.out_a;
    assign compare_b_output = s_q.out_b;
    assign irq_req          = s_q.flags & s_q.mask;
    assign at_bottom        = s_q.count == TM16_BOTTOM;
    assign at_max           = s_q.count == TM16_MAX;
endmodule // tm16_timer

// file: tb/tm16_timer_props.sv
// Purpose: port checks for tm16_timer
// Assumes: shadows follow accepted bus writes
// Notes:   staging shadow is void after a count or capture low read
`timescale 1ns/1ps
module tm16_timer_props (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // register bus
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // status
    input wire logic [3:0]  irq_req,
    input wire logic        at_bottom,
    input wire logic        at_max
);
    import tm16_pkg::*;
    logic [7:0]  ca_q, cb_q, stg_q;
    logic [3:0]  msk_q;
    logic [15:0] lo_val;
    logic        pwr_q, stg_ok_q, req, wr_acc, stop, lo_wr;
    assign req    = avs_read | avs_write;
    assign wr_acc = avs_write & ~avs_waitrequest;
    assign stop   = pwr_q | (cb_q[2:0] == TM16_CS_STOP);
    assign lo_wr  = wr_acc & (avs_address == TM16_OFS_COUNT_LO);
    assign lo_val = {stg_q, avs_writedata[7:0]};
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ca_q     <= 8'h00;
            cb_q     <= 8'h00;
            stg_q    <= 8'h00;
            msk_q    <= 4'h0;
            pwr_q    <= 1'b0;
            stg_ok_q <= 1'b1;
        end else if (wr_acc) begin
            case (avs_address)
                TM16_OFS_CONTROL_A: ca_q <= avs_writedata[7:0];
                TM16_OFS_CONTROL_B: cb_q <= avs_writedata[7:0];
                TM16_OFS_INT_MASK: msk_q <= avs_writedata[3:0];
                TM16_OFS_POWER: pwr_q <= avs_writedata[0];
                TM16_OFS_COUNT_HI, TM16_OFS_CMP_A_HI, TM16_OFS_CMP_B_HI, TM16_OFS_CAPTURE_HI: begin
                    stg_q    <= avs_writedata[7:0];
                    stg_ok_q <= 1'b1;
                end
                default: ;
            endcase
        end else if (avs_read && (avs_address == TM16_OFS_COUNT_LO || avs_address == TM16_OFS_CAPTURE_LO)) begin
            stg_ok_q <= 1'b0;
        end
    end
    a_wait_first:
    assert property (@(posedge mclk) disable iff (rst) req && !$past(req) |-> avs_waitrequest)
        else $error("waitrequest low in first request cycle");
    a_wait_answer:
    assert property (@(posedge mclk) disable iff (rst) req && avs_waitrequest |=> !avs_waitrequest || !req)
        else $error("no answer one cycle after request");
    a_read_upper:
    assert property (@(posedge mclk) disable iff (rst) avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_ends_apart:
    assert property (@(posedge mclk) disable iff (rst) !(at_bottom && at_max))
        else $error("bottom and max at once");
    a_stop_holds:
    assert property (@(posedge mclk) disable iff (rst) stop && !lo_wr |=> $stable(at_bottom) && $stable(at_max))
        else $error("count moved with no clock source");
    a_max_wraps:
    assert property (@(posedge mclk) disable iff (rst)
        !stop && cb_q[2:0] == TM16_CS_DIV1 && {cb_q[4:3], ca_q[1:0]} == 4'h0 && at_max && !lo_wr |=> at_bottom)
        else $error("no wrap from max to bottom");
    a_low_write:
    assert property (@(posedge mclk) disable iff (rst) lo_wr && stg_ok_q
        |=> at_bottom == ($past(lo_val) == TM16_BOTTOM) && at_max == ($past(lo_val) == TM16_MAX))
        else $error("low write did not load the count");
    a_irq_masked:
    assert property (@(posedge mclk) disable iff (rst) (irq_req & ~msk_q) == 4'h0)
        else $error("request passes a cleared mask bit");
    a_hi_write_only:
    assert property (@(posedge mclk) disable iff (rst)
        wr_acc && avs_address == TM16_OFS_COUNT_HI && stop |=> $stable(at_bottom) && $stable(at_max))
        else $error("high write changed the count");
endmodule // tm16_timer_props

bind tm16_timer tm16_timer_props tm16_timer_props_inst (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_req(irq_req), .at_bottom(at_bottom), .at_max(at_max)
);

// file: tb/tm16_cpu_model.sv
// Purpose: CPU-side master on the timer register bus
// Assumes: one thread of software, no interrupt code in between
// Notes:   released lines show inverted data so stale values never match
`timescale 1ns/1ps
module tm16_cpu_model (
    // clock
    input  wire logic        mclk,
    // register bus
    output logic [5:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    logic        wait_s;
    logic [31:0] rdata_s;
    initial begin
        avs_address   = 6'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h00000000;
    end
    // mid-cycle sample is what the next rising edge meets
    always @(negedge mclk) begin
        wait_s  = avs_waitrequest;
        rdata_s = avs_readdata;
    end
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do @(posedge mclk); while (wait_s);
        q = rdata_s;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= {24'hffffff, ~d};
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask
    task automatic w16(input logic [5:0] lo, input logic [15:0] v);
        wr(lo + 6'h04, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic r16(input logic [5:0] lo, output logic [15:0] v);
        logic [31:0] q;
        rd(lo, q);
        v[7:0] = q[7:0];
        rd(lo + 6'h04, q);
        v[15:8] = q[7:0];
    endtask
endmodule // tm16_cpu_model

// file: tb/tm16_timer_tb.sv
// Purpose: self-checking bench for tm16_timer
// Assumes: cpu model drives the register bus
// Notes:   pins change by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module tm16_timer_tb;
    import tm16_pkg::*;
    logic        mclk, rst, rd, wr, waitreq, at_bottom, at_max, out_a, out_b;
    logic [2:0]  pins;
    logic [5:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [3:0]  irq;
    logic [15:0] v;
    int          fails, num_checks, cyc, i;
    tm16_timer #(.FILTER_TAPS(4)) tm16_timer_inst (
        .mclk(mclk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_readdata(rdata), .avs_waitrequest(waitreq), .external_clock_pin(pins[2]),
        .capture_input_pin(pins[0]), .analog_cmp_in(pins[1]), .compare_a_output(out_a),
        .compare_b_output(out_b), .irq_req(irq), .at_bottom(at_bottom), .at_max(at_max)
    );
    tm16_cpu_model tm16_cpu_model_inst (
        .mclk(mclk), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_readdata(rdata), .avs_waitrequest(waitreq)
    );
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;
    task automatic complete_run();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            complete_run();
        end
    end
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rdc(input string n, input logic [5:0] a, input logic [31:0] exp);
        tm16_cpu_model_inst.rd(a, q);
        check(n, q, exp);
    endtask
    task automatic r16c(input string n, input logic [5:0] lo, input logic [15:0] exp);
        tm16_cpu_model_inst.r16(lo, v);
        check(n, {16'h0000, v}, {16'h0000, exp});
    endtask
    task automatic w8(input logic [5:0] a, input logic [7:0] d);
        tm16_cpu_model_inst.wr(a, d);
    endtask
    task automatic w16(input logic [5:0] lo, input logic [15:0] d);
        tm16_cpu_model_inst.w16(lo, d);
    endtask
    // waits for the count to reach bottom, then stops the clock
    task automatic wrap_within(input string n);
        int k;
        k = 0;
        while (at_bottom !== 1'b1 && k < 50) begin
            @(negedge mclk);
            k++;
        end
        w8(TM16_OFS_CONTROL_B, 8'h00);
        check(n, {31'h0, k < 50}, 32'h1);
    endtask
    task automatic pulse(input int which, input int n);
        @(posedge mclk);
        pins[which] <= 1'b1;
        repeat (n) @(posedge mclk);
        pins[which] <= 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask
    initial begin
        rst = 1'b1;
        pins = 3'b000;
        fails = 0;
        num_checks = 0;
        cyc = 0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i <= 13; i++) begin
            rdc("reset value", 6'(i * 4), 32'h0);
        end
        check("bottom", {31'h0, at_bottom}, 32'h1);
        w8(TM16_OFS_CONTROL_A, 8'hf0);
        rdc("control_a", TM16_OFS_CONTROL_A, 32'hf0);
        w8(6'h34, 8'hff);
        rdc("unmapped", 6'h34, 32'h0);
        w16(TM16_OFS_COUNT_LO, 16'h1234);
        r16c("count", TM16_OFS_COUNT_LO, 16'h1234);
        w8(TM16_OFS_COUNT_HI, 8'h56);
        r16c("count kept", TM16_OFS_COUNT_LO, 16'h1234);
        w8(TM16_OFS_CMP_A_HI, 8'h77);
        w8(TM16_OFS_CMP_A_LO, 8'h01);
        w8(TM16_OFS_CMP_B_LO, 8'h02);
        rdc("count lo", TM16_OFS_COUNT_LO, 32'h34);
        rdc("staged hi", TM16_OFS_COUNT_HI, 32'h12);
        rdc("cmp a hi", TM16_OFS_CMP_A_HI, 32'h77);
        r16c("cmp b", TM16_OFS_CMP_B_LO, 16'h7702);
        w8(TM16_OFS_INT_MASK, 8'h08);
        for (i = 0; i < 2; i++) begin
            w8(TM16_OFS_CONTROL_B, 8'h47 | 8'(i << 5));
            pulse(i, 3);
            check("capture irq", {28'h0, irq}, 32'h8);
            r16c("capture", TM16_OFS_CAPTURE_LO, 16'h1234);
            w8(TM16_OFS_INT_FLAGS, 8'h08);
            @(negedge mclk);
            check("flag cleared", {28'h0, irq}, 32'h0);
        end
        w8(TM16_OFS_CONTROL_B, 8'hc7);
        pulse(0, 1);
        rdc("spike", TM16_OFS_INT_FLAGS, 32'h0);
        pulse(0, 8);
        rdc("filtered", TM16_OFS_INT_FLAGS, 32'h8);
        w8(TM16_OFS_INT_FLAGS, 8'h08);
        w8(TM16_OFS_POWER, 8'h01);
        pulse(0, 8);
        rdc("powered off", TM16_OFS_INT_FLAGS, 32'h0);
        w8(TM16_OFS_POWER, 8'h00);
        w16(TM16_OFS_COUNT_LO, 16'h0000);
        for (i = 0; i < 2; i++) begin
            w8(TM16_OFS_CONTROL_B, 8'h07 - 8'(i));
            repeat (3) pulse(2, 2);
            r16c("external", TM16_OFS_COUNT_LO, 16'(3 * i + 3));
        end
        w8(TM16_OFS_INT_MASK, 8'h07);
        w16(TM16_OFS_CMP_A_LO, 16'hfffd);
        w16(TM16_OFS_CMP_B_LO, 16'hfffe);
        w8(TM16_OFS_CONTROL_B, {5'h00, TM16_CS_DIV1});
        w16(TM16_OFS_COUNT_LO, 16'hfffa);
        wrap_within("wrap seen");
        rdc("flags", TM16_OFS_INT_FLAGS, 32'h7);
        check("irq", {28'h0, irq}, 32'h7);
        check("outputs", {30'h0, out_b, out_a}, 32'h3);
        w8(TM16_OFS_CONTROL_A, 8'hf1);
        w16(TM16_OFS_COUNT_LO, 16'h00fb);
        w8(TM16_OFS_CONTROL_B, {5'h00, TM16_CS_DIV1});
        wrap_within("fixed top");
        complete_run();
    end
endmodule // tm16_timer_tb
